/* gtm_cfg.svh */
// Register offsets, field positions and reset values of the split 16-bit timer
`ifndef GTM_CFG_SVH
`define GTM_CFG_SVH

`define GTM_OFS_CFG     8'h00
`define GTM_OFS_MODE_A  8'h04
`define GTM_OFS_MODE_B  8'h08
`define GTM_OFS_CTL     8'h0C
`define GTM_OFS_IMR     8'h18
`define GTM_OFS_RIS     8'h1C
`define GTM_OFS_MIS     8'h20
`define GTM_OFS_ICR     8'h24
`define GTM_OFS_ILR_A   8'h28
`define GTM_OFS_ILR_B   8'h2C
`define GTM_OFS_MATCH_A 8'h30
`define GTM_OFS_MATCH_B 8'h34
`define GTM_OFS_PR_A    8'h38
`define GTM_OFS_PR_B    8'h3C
`define GTM_OFS_CNT_A   8'h48
`define GTM_OFS_CNT_B   8'h4C

`define GTM_CFG_16BIT   3'h4
`define GTM_MODE_ONE    2'h1
`define GTM_MODE_PER    2'h2
`define GTM_MODE_CAP    2'h3
`define GTM_CTL_STRIDE  8
`define GTM_CTL_EN      0
`define GTM_CTL_STALL   1
`define GTM_CTL_EVT     2
`define GTM_CTL_POL     6
`define GTM_FLAG_TO     0
`define GTM_FLAG_CM     1
`define GTM_FLAG_CE     2
`define GTM_EVT_RISE    2'h0
`define GTM_EVT_FALL    2'h1
`define GTM_EVT_BOTH    2'h3
`define GTM_ILR_RST     16'hFFFF
`define GTM_PR_RST      8'h00

`endif

/* gtm_pkg.sv */
// Types shared by the split 16-bit timer
`default_nettype none
package gtm_pkg;
  typedef struct packed {
    logic [2:0]       cfg;
    logic [1:0][3:0]  mode;
    logic [1:0]       en;
    logic [1:0]       stall;
    logic [1:0]       pol;
    logic [1:0][1:0]  evt;
    logic [1:0][2:0]  imr;
    logic [1:0][2:0]  ris;
    logic [1:0][15:0] ilr;
    logic [1:0][15:0] match;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] cap;
    logic [1:0][7:0]  pr;
    logic [1:0][7:0]  pres;
    logic [1:0]       ldp;
    logic [1:0]       s1;
    logic [1:0]       s2;
    logic [1:0]       s3;
    logic [1:0]       pwm;
    logic [1:0]       ccp_o;
    logic [1:0]       oe_n;
    logic             irq;
    logic [31:0]      prdata;
    logic             pslverr;
  } gtm_state_s;
endpackage
`default_nettype wire

/* gtm_timer16.sv */
// Split 16-bit timer pair with APB register access
//
// Summary of operation
// - Configuration value 0x4 selects independent 16-bit timers
// - One-shot/periodic: 16-bit down-counter with 8-bit prescaler
// - Count from preload; reload counter and prescaler after zero
// - One-shot stops and clears enable; periodic continues
// - Zero sets sticky timeout flag; masked raises interrupt
// - Interval load write reloads counter next cycle
// - Stall bit freezes counter during debug halt
// - No prescaling in edge count, edge time, PWM
// - Capture bit clear selects edge count; event picks edges
// - Each selected edge decrements until match value
// - Count match sets raw match flag; masked flag only if its mask bit is set
// - After match reload, clear enable, ignore edges
// - Capture bit set selects free-running edge time
// - Selected edge copies count and sets event flags
// - Capture held until next edge; reload at zero
// - PWM: alternate bit 1, capture bit 0, mode 2
// - PWM counts down, reloads, no status flags
// - PWM asserts at load value, drops at match
// - Polarity bit inverts the PWM output
// - Mode field: 1 one-shot, 2 periodic
// - Edge capture modes need mode field 3
// - Load resets to FFFF, prescale to 00, controls cleared
//
// The address map and the APB interface to the registers were chosen for this implementation.
`include "gtm_cfg.svh"
`default_nettype none
module gtm_timer16 #(
  parameter int ADDR_W = 12
) (
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic                   pready_out,
  output logic [31:0]            prdata_out,
  output logic                   pslverr_out,
  input  wire logic              dbg_halt_in,
  input  wire logic              ccp_a_in,
  output logic                   ccp_a_out,
  output logic                   ccp_a_oe_n_out,
  input  wire logic              ccp_b_in,
  output logic                   ccp_b_out,
  output logic                   ccp_b_oe_n_out,
  output logic                   irq_out
);

  gtm_pkg::gtm_state_s q;
  gtm_pkg::gtm_state_s next_q;
  logic [1:0] pin;

  assign pin = {ccp_b_in, ccp_a_in};

  // Edge qualifier; code 2 of the event field selects no edge
  function automatic logic edge_hit(input logic [1:0] evt, input logic cur, input logic prev);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    unique case (evt)
      `GTM_EVT_RISE: edge_hit = rise;
      `GTM_EVT_FALL: edge_hit = fall;
      `GTM_EVT_BOTH: edge_hit = rise | fall;
      default:       edge_hit = 1'b0;
    endcase
  endfunction

  // Read decode; bit 32 flags an unmapped address
  function automatic logic [32:0] read_mux(input gtm_pkg::gtm_state_s s, input logic [7:0] a);
    logic [31:0] d;
    logic        err;
    d = 32'h0000_0000;
    err = 1'b0;
    case (a)
      `GTM_OFS_CFG:     d[2:0] = s.cfg;
      `GTM_OFS_MODE_A:  d[3:0] = s.mode[0];
      `GTM_OFS_MODE_B:  d[3:0] = s.mode[1];
      `GTM_OFS_CTL: begin
        for (int i = 0; i < 2; i++) begin
          d[`GTM_CTL_STRIDE*i + `GTM_CTL_EN] = s.en[i];
          d[`GTM_CTL_STRIDE*i + `GTM_CTL_STALL] = s.stall[i];
          d[`GTM_CTL_STRIDE*i + `GTM_CTL_EVT +: 2] = s.evt[i];
          d[`GTM_CTL_STRIDE*i + `GTM_CTL_POL] = s.pol[i];
        end
      end
      `GTM_OFS_IMR:     d = {21'h000000, s.imr[1], 5'h00, s.imr[0]};
      `GTM_OFS_RIS:     d = {21'h000000, s.ris[1], 5'h00, s.ris[0]};
      `GTM_OFS_MIS:     d = {21'h000000, s.ris[1] & s.imr[1], 5'h00, s.ris[0] & s.imr[0]};
      `GTM_OFS_ICR:     d = 32'h0000_0000;
      `GTM_OFS_ILR_A:   d[15:0] = s.ilr[0];
      `GTM_OFS_ILR_B:   d[15:0] = s.ilr[1];
      `GTM_OFS_MATCH_A: d[15:0] = s.match[0];
      `GTM_OFS_MATCH_B: d[15:0] = s.match[1];
      `GTM_OFS_PR_A:    d[7:0] = s.pr[0];
      `GTM_OFS_PR_B:    d[7:0] = s.pr[1];
      // Edge time and mode value 0xF show the held capture, all other modes the live count
      `GTM_OFS_CNT_A:   d[15:0] = (s.mode[0][2:0] == {1'b1, `GTM_MODE_CAP}) ? s.cap[0] : s.cnt[0];
      `GTM_OFS_CNT_B:   d[15:0] = (s.mode[1][2:0] == {1'b1, `GTM_MODE_CAP}) ? s.cap[1] : s.cnt[1];
      default:          err = 1'b1;
    endcase
    read_mux = {err, d};
  endfunction

  always_comb begin
    logic        act;
    logic        hit;
    logic [1:0]  md;
    logic        cmr;
    logic        ams;
    logic [15:0] dec;
    logic [32:0] rd;
    act = 1'b0;
    hit = 1'b0;
    md = 2'h0;
    cmr = 1'b0;
    ams = 1'b0;
    dec = 16'h0000;
    rd = read_mux(q, paddr_in[7:0]);
    next_q = q;
    next_q.ldp = 2'b00;
    // Read data latched in setup so it is stable through the access phase
    if (psel_in && !penable_in) begin
      next_q.prdata = rd[31:0];
      next_q.pslverr = rd[32] | (|paddr_in[ADDR_W-1:8]);
    end
    if (psel_in && penable_in && pwrite_in && !q.pslverr) begin
      case (paddr_in[7:0])
        `GTM_OFS_CFG:    next_q.cfg = pwdata_in[2:0];
        `GTM_OFS_MODE_A: next_q.mode[0] = pwdata_in[3:0];
        `GTM_OFS_MODE_B: next_q.mode[1] = pwdata_in[3:0];
        `GTM_OFS_CTL: begin
          for (int i = 0; i < 2; i++) begin
            next_q.en[i] = pwdata_in[`GTM_CTL_STRIDE*i + `GTM_CTL_EN];
            next_q.stall[i] = pwdata_in[`GTM_CTL_STRIDE*i + `GTM_CTL_STALL];
            next_q.evt[i] = pwdata_in[`GTM_CTL_STRIDE*i + `GTM_CTL_EVT +: 2];
            next_q.pol[i] = pwdata_in[`GTM_CTL_STRIDE*i + `GTM_CTL_POL];
          end
        end
        `GTM_OFS_IMR: begin
          next_q.imr[0] = pwdata_in[2:0];
          next_q.imr[1] = pwdata_in[10:8];
        end
        `GTM_OFS_ICR: begin
          next_q.ris[0] = q.ris[0] & ~pwdata_in[2:0];
          next_q.ris[1] = q.ris[1] & ~pwdata_in[10:8];
        end
        `GTM_OFS_ILR_A: begin
          next_q.ilr[0] = pwdata_in[15:0];
          next_q.ldp[0] = 1'b1;
        end
        `GTM_OFS_ILR_B: begin
          next_q.ilr[1] = pwdata_in[15:0];
          next_q.ldp[1] = 1'b1;
        end
        `GTM_OFS_MATCH_A: next_q.match[0] = pwdata_in[15:0];
        `GTM_OFS_MATCH_B: next_q.match[1] = pwdata_in[15:0];
        `GTM_OFS_PR_A:    next_q.pr[0] = pwdata_in[7:0];
        `GTM_OFS_PR_B:    next_q.pr[1] = pwdata_in[7:0];
        default: ;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      next_q.s1[i] = pin[i];
      next_q.s2[i] = q.s1[i];
      next_q.s3[i] = q.s2[i];
      hit = edge_hit(q.evt[i], q.s2[i], q.s3[i]);
      md = q.mode[i][1:0];
      cmr = q.mode[i][2];
      ams = q.mode[i][3];
      dec = q.cnt[i] - 16'h0001;
      // Only the global 16-bit arrangement runs these timers
      act = (q.cfg == `GTM_CFG_16BIT) && q.en[i] && !(q.stall[i] && dbg_halt_in);
      if (q.ldp[i]) begin
        next_q.cnt[i] = q.ilr[i];
        next_q.pres[i] = q.pr[i];
      end else if (act) begin
        if (ams && !cmr && md == `GTM_MODE_PER) begin
          // PWM: no prescaler, no flags
          next_q.cnt[i] = (q.cnt[i] == 16'h0000) ? q.ilr[i] : dec;
          if (q.cnt[i] == q.ilr[i]) begin
            next_q.pwm[i] = 1'b1;
          end else if (q.cnt[i] == q.match[i]) begin
            next_q.pwm[i] = 1'b0;
          end
        end else if (!ams && md == `GTM_MODE_CAP && !cmr) begin
          // Guard keeps a count already at match from wrapping
          if (hit && q.cnt[i] != q.match[i]) begin
            next_q.cnt[i] = dec;
            if (dec == q.match[i]) begin
              next_q.ris[i][`GTM_FLAG_CM] = 1'b1;
              next_q.cnt[i] = q.ilr[i];
              next_q.en[i] = 1'b0;
            end
          end
        end else if (!ams && md == `GTM_MODE_CAP) begin
          next_q.cnt[i] = (q.cnt[i] == 16'h0000) ? q.ilr[i] : dec;
          if (hit) begin
            next_q.cap[i] = q.cnt[i];
            next_q.ris[i][`GTM_FLAG_CE] = 1'b1;
          end
        end else if (!ams && (md == `GTM_MODE_ONE || md == `GTM_MODE_PER)) begin
          if (q.pres[i] != 8'h00) begin
            next_q.pres[i] = q.pres[i] - 8'h01;
          end else begin
            next_q.pres[i] = q.pr[i];
            if (q.cnt[i] == 16'h0000) begin
              next_q.cnt[i] = q.ilr[i];
              next_q.ris[i][`GTM_FLAG_TO] = 1'b1;
              if (md == `GTM_MODE_ONE) begin
                next_q.en[i] = 1'b0;
              end
            end else begin
              next_q.cnt[i] = dec;
            end
          end
        end
      end
      next_q.ccp_o[i] = next_q.pwm[i] ^ next_q.pol[i];
      next_q.oe_n[i] = !(next_q.cfg == `GTM_CFG_16BIT && next_q.mode[i] == {2'b10, `GTM_MODE_PER});
    end
    next_q.irq = |{next_q.ris[1] & next_q.imr[1], next_q.ris[0] & next_q.imr[0]};
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
      q.ilr <= {`GTM_ILR_RST, `GTM_ILR_RST};
      q.cnt <= {`GTM_ILR_RST, `GTM_ILR_RST};
      q.pr <= {`GTM_PR_RST, `GTM_PR_RST};
      q.pres <= {`GTM_PR_RST, `GTM_PR_RST};
      q.oe_n <= 2'b11;
    end else begin
      q <= next_q;
    end
  end

  assign pready_out = psel_in & penable_in;
  assign prdata_out = q.prdata;
  assign pslverr_out = q.pslverr & psel_in & penable_in;
  assign ccp_a_out = q.ccp_o[0];
  assign ccp_b_out = q.ccp_o[1];
  assign ccp_a_oe_n_out = q.oe_n[0];
  assign ccp_b_oe_n_out = q.oe_n[1];
  assign irq_out = q.irq;

  // Checks on timer A
  logic a_run;
  logic a_os;
  logic a_pwm;
  logic a_ec;
  logic a_et;
  logic a_hit;
  assign a_run = (q.cfg == `GTM_CFG_16BIT) && q.en[0] && !(q.stall[0] && dbg_halt_in) && !q.ldp[0];
  assign a_os = a_run && q.mode[0][3:2] == 2'b00 && q.mode[0][1:0] != `GTM_MODE_CAP
                && q.mode[0][1:0] != 2'b00;
  assign a_pwm = a_run && q.mode[0] == {2'b10, `GTM_MODE_PER};
  assign a_ec = a_run && q.mode[0] == {2'b00, `GTM_MODE_CAP};
  assign a_et = a_run && q.mode[0] == {2'b01, `GTM_MODE_CAP};
  assign a_hit = edge_hit(q.evt[0], q.s2[0], q.s3[0]);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  sequence ec_match_s;
    a_ec && a_hit && q.cnt[0] != q.match[0] && (q.cnt[0] - 16'h0001) == q.match[0];
  endsequence
  sequence ec_stopped_s;
    !q.en[0] && q.ris[0][`GTM_FLAG_CM];
  endsequence

  cfg_gate_a: assert property ((q.cfg != `GTM_CFG_16BIT) && !q.ldp[0]
    |=> $stable(q.cnt[0]))
    else $error("counter moved outside 16-bit arrangement");
  prescale_hold_a: assert property (a_os && q.pres[0] != 8'h00
    |=> $stable(q.cnt[0]) && q.pres[0] == $past(q.pres[0]) - 8'h01)
    else $error("prescaler did not gate the counter");
  zero_reload_a: assert property (a_os && q.pres[0] == 8'h00 && q.cnt[0] == 16'h0000
    |=> q.cnt[0] == $past(q.ilr[0]) && q.pres[0] == $past(q.pr[0])
    && q.ris[0][`GTM_FLAG_TO])
    else $error("timeout reload wrong");
  oneshot_stop_a: assert property (a_os && q.mode[0][1:0] == `GTM_MODE_ONE && q.pres[0] == 8'h00
    && q.cnt[0] == 16'h0000 |=> !q.en[0] ##1 $stable(q.cnt[0]))
    else $error("one-shot kept running");
  irq_mask_a: assert property (q.ris[0][`GTM_FLAG_TO] && q.imr[0][`GTM_FLAG_TO] |-> irq_out)
    else $error("unmasked timeout without interrupt");
  load_write_a: assert property (q.ldp[0] |=> q.cnt[0] == $past(q.ilr[0]))
    else $error("interval load not taken next cycle");
  debug_stall_a: assert property (q.en[0] && q.stall[0] && dbg_halt_in && !q.ldp[0]
    |=> $stable(q.cnt[0]))
    else $error("counter moved during debug halt");
  edge_match_a: assert property (ec_match_s |=> ec_stopped_s ##0 q.cnt[0] == $past(q.ilr[0]))
    else $error("edge count match handling wrong");
  capture_copy_a: assert property (a_et && a_hit
    |=> q.cap[0] == $past(q.cnt[0]) && q.ris[0][`GTM_FLAG_CE])
    else $error("edge time capture wrong");
  pwm_noflag_a: assert property (a_pwm |=> (q.ris[0] & ~$past(q.ris[0])) == 3'b000)
    else $error("flag raised in PWM mode");
  pwm_rise_a: assert property (a_pwm && q.cnt[0] == q.ilr[0] |=> q.pwm[0])
    else $error("PWM did not assert at load value");
  pwm_polarity_a: assert property (q.ccp_o[0] == (q.pwm[0] ^ q.pol[0]))
    else $error("PWM polarity wrong");

endmodule
`default_nettype wire

/* gtm_pin_model.sv */
// Edge source and PWM load standing on one capture/compare pin
`default_nettype none
module gtm_pin_model (
  input  wire logic core_clk_in,
  input  wire logic want_in,
  input  wire logic drv_in,
  input  wire logic drv_oe_n_in,
  output logic      pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        lvl;
  int unsigned hold;
  initial begin
    lvl  = 1'b0;
    hold = 0;
  end
  // Each new level is kept four clocks, so edges never come faster than 1/4 clock
  always @(posedge core_clk_in) begin
    if (hold != 0) begin
      hold <= hold - 1;
    end else if (want_in !== lvl) begin
      lvl  <= want_in;
      hold <= 3;
    end
  end
  // The timer wins the wire while it drives
  assign pin_out = drv_oe_n_in ? lvl : drv_in;
endmodule
`default_nettype wire

/* gtm_timer16_tb_top.sv */
// Self-checking bench of the split 16-bit timer
`include "gtm_cfg.svh"
`default_nettype none
module gtm_timer16_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, pen, pwr, halt, want_a, want_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, rd_err, a_in, a_out, a_oen, b_in, b_out, b_oen, irq;
  int          n_fail, n_checks;
  gtm_timer16 dut_u (.core_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready),
    .prdata_out(prdata), .pslverr_out(pslverr), .dbg_halt_in(halt), .ccp_a_in(a_in),
    .ccp_a_out(a_out), .ccp_a_oe_n_out(a_oen), .ccp_b_in(b_in), .ccp_b_out(b_out),
    .ccp_b_oe_n_out(b_oen), .irq_out(irq));
  gtm_pin_model pin_a_u (.core_clk_in(clk), .want_in(want_a), .drv_in(a_out),
    .drv_oe_n_in(a_oen), .pin_out(a_in));
  gtm_pin_model pin_b_u (.core_clk_in(clk), .want_in(want_b), .drv_in(b_out),
    .drv_oe_n_in(b_oen), .pin_out(b_in));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= {4'h0, a};
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (int i = 0; i < 20 && !done; i++) begin
      @(posedge clk);
      done = (pready === 1'b1);
    end
    rd     = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    // Idle edge, so the next call never re-drives psel in this time step
    @(posedge clk);
    if (!done) begin
      n_fail++;
      print_verdict();
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic sc_reset();
    rd_chk(`GTM_OFS_ILR_A, 32'h0000FFFF);
    rd_chk(`GTM_OFS_ILR_B, 32'h0000FFFF);
    rd_chk(`GTM_OFS_PR_A, 32'h00000000);
    rd_chk(`GTM_OFS_CTL, 32'h00000000);
    rd_chk(`GTM_OFS_CNT_A, 32'h0000FFFF);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, rd_err}, 32'h0000_0001);
  endtask
  task automatic sc_one_shot();
    int n;
    n = 0;
    apb(1'b1, `GTM_OFS_CFG, 32'h00000004);
    apb(1'b1, `GTM_OFS_MODE_A, 32'h00000001);
    apb(1'b1, `GTM_OFS_PR_A, 32'h00000001);
    apb(1'b1, `GTM_OFS_ILR_A, 32'h00000005);
    apb(1'b1, `GTM_OFS_IMR, 32'h00000001);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000001);
    while (irq !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    // Six counts of two clocks each, plus flag and interrupt latency
    chk(n >= 11 && n <= 16, 1);
    rd_chk(`GTM_OFS_CTL, 32'h00000000);
    rd_chk(`GTM_OFS_MIS, 32'h00000001);
    cyc(20);
    rd_chk(`GTM_OFS_RIS, 32'h00000001);
    apb(1'b1, `GTM_OFS_ICR, 32'h00000001);
    rd_chk(`GTM_OFS_RIS, 32'h00000000);
    cyc(2);
    chk(irq, 1'b0);
  endtask
  task automatic sc_periodic_stall();
    logic [31:0] c1;
    apb(1'b1, `GTM_OFS_MODE_B, 32'h00000002);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000300);
    cyc(10);
    halt <= 1'b1;
    cyc(2);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    c1 = rd;
    cyc(10);
    rd_chk(`GTM_OFS_CNT_B, c1);
    halt <= 1'b0;
    cyc(5);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    chk(rd < c1, 1);
    apb(1'b1, `GTM_OFS_ILR_B, 32'h00000040);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    chk(rd <= 32'h00000040 && rd >= 32'h00000038, 1);
    cyc(150);
    rd_chk(`GTM_OFS_CTL, 32'h00000300);
    rd_chk(`GTM_OFS_RIS, 32'h00000100);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000000);
    apb(1'b1, `GTM_OFS_ICR, 32'h00000100);
  endtask
  task automatic toggle_a(input int n);
    repeat (n) begin
      want_a <= ~want_a;
      cyc(8);
    end
  endtask
  task automatic sc_edge_count();
    apb(1'b1, `GTM_OFS_MODE_A, 32'h00000003);
    apb(1'b1, `GTM_OFS_PR_A, 32'h00000005);
    apb(1'b1, `GTM_OFS_ILR_A, 32'h0000000A);
    apb(1'b1, `GTM_OFS_MATCH_A, 32'h00000006);
    apb(1'b1, `GTM_OFS_CTL, 32'h0000000D);
    toggle_a(2);
    rd_chk(`GTM_OFS_CNT_A, 32'h00000008);
    toggle_a(2);
    rd_chk(`GTM_OFS_RIS, 32'h00000002);
    rd_chk(`GTM_OFS_CTL, 32'h0000000C);
    toggle_a(2);
    rd_chk(`GTM_OFS_CNT_A, 32'h0000000A);
    apb(1'b1, `GTM_OFS_ICR, 32'h00000002);
  endtask
  task automatic sc_edge_time();
    logic [31:0] c1;
    apb(1'b1, `GTM_OFS_ILR_B, 32'h0000FFFF);
    apb(1'b1, `GTM_OFS_MODE_B, 32'h00000007);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000100);
    cyc(30);
    want_b <= 1'b1;
    cyc(8);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    c1 = rd;
    chk(c1 < 32'h0000FFFF && c1 > 32'h0000FF00, 1);
    rd_chk(`GTM_OFS_RIS, 32'h00000400);
    want_b <= 1'b0;
    cyc(20);
    rd_chk(`GTM_OFS_CNT_B, c1);
    want_b <= 1'b1;
    cyc(8);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    chk(rd < c1 && rd > c1 - 32'h40, 1);
    c1 = rd;
    chk({30'h0, b_out, b_oen}, 32'h00000001);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000500);
    want_b <= 1'b0;
    cyc(8);
    apb(1'b0, `GTM_OFS_CNT_B, 32'h0);
    chk(rd < c1 && rd > c1 - 32'h20, 1);
    apb(1'b1, `GTM_OFS_CTL, 32'h00000000);
    apb(1'b1, `GTM_OFS_ICR, 32'h00000707);
  endtask
  // High share of the output over two whole periods of ten clocks
  task automatic pwm_run(input logic [31:0] ctl, input int exp_high);
    int h;
    h = 0;
    apb(1'b1, `GTM_OFS_CTL, ctl);
    cyc(30);
    repeat (20) begin
      @(posedge clk);
      h += (a_out === 1'b1);
    end
    chk(h, exp_high);
    chk(a_oen, 1'b0);
  endtask
  task automatic sc_pwm();
    apb(1'b1, `GTM_OFS_MODE_A, 32'h0000000A);
    apb(1'b1, `GTM_OFS_ILR_A, 32'h00000009);
    apb(1'b1, `GTM_OFS_MATCH_A, 32'h00000002);
    pwm_run(32'h00000001, 14);
    pwm_run(32'h00000041, 6);
    rd_chk(`GTM_OFS_RIS, 32'h00000000);
  endtask
  initial begin
    n_fail = 0;
    n_checks = 0;
    rst = 1'b1;
    {psel, pen, pwr, halt, want_a, want_b} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    cyc(6);
    rst <= 1'b0;
    @(posedge clk);
    sc_reset();
    sc_one_shot();
    sc_periodic_stall();
    sc_edge_count();
    sc_edge_time();
    sc_pwm();
    print_verdict();
  end
endmodule
`default_nettype wire
